/* verilog/acb_contrast_boost.sv */
// Adaptive contrast boost stage with its secondary page registers
// Notes on behaviour
// R1 - Brighten bright areas, darken dark areas
// R2 - Histogram luma, correct whole image nonlinearly
// R3 - Enhancement stays disabled after reset
// R4 - Enable bit 7 at 0x80, default off
// R5 - Host selects secondary page via 0x0E
// R6 - Host enables by writing 0x80 there
// R7 - Luma contrast level 0x83[4:0], default 01101
// R8 - Saturation level 0x84[3:0], default 1000
// R9 - Clip chroma gain to 0x84[7:4]
// R10 - Response speed 0x85[7:4], default 1111
// R11 - Alpha blend, faster for larger speed
// R12 - Dark stretch 0x85[3:0] on dark pixels
// R13 - Host prefers level fields over stretch
// R14 - Disabled: samples pass unchanged, fixed latency
// R15 - Parameter changes take effect at frames
`timescale 1ns/10ps
`include "acb_defs.svh"
module acb_contrast_boost
    import acb_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic reg_wr_en,         // Serial port write strobe
    input wire logic reg_rd_en,         // Serial port read strobe
    input wire logic [7:0] reg_addr,    // Sub-address within the page
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic frame_start,       // First pixel of a frame
    input wire logic pix_valid,
    input wire logic [7:0] pix_y,       // Luma sample
    input wire logic [7:0] pix_c,       // Chroma sample, offset binary
    output logic out_valid,
    output logic [7:0] out_y,
    output logic [7:0] out_c
);

    // ==========================================================
    // Helpers
    // ==========================================================
    // Saturate a signed intermediate onto the 8-bit sample range
    function automatic logic [7:0] clamp8(input logic signed [19:0] v);
        if (v < 0) begin
            return 8'h00;
        end else if (v > 20'sh000ff) begin
            return 8'hff;
        end
        return v[7:0];
    endfunction

    // Secondary page decode, used by writes and reads
    function automatic logic on_second(input logic [7:0] pg);
        return pg == `ACB_PAGE_SECOND;
    endfunction

    acb_state_t st_q; // Registered state
    acb_state_t st_d; // Next state

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic signed [19:0] dev;
        logic signed [19:0] yc;
        logic signed [19:0] cc;
        logic signed [19:0] by;
        logic signed [19:0] bc;
        logic [4:0] lg;
        logic [3:0] gmin;
        logic [4:0] cur_luma;   // Curve settings seen by this cycle's pixel
        logic [3:0] cur_gain;
        logic [3:0] cur_stretch;
        logic cur_dark;         // Histogram verdict seen by this cycle's pixel
        dev = 20'sh0;
        yc = 20'sh0;
        cc = 20'sh0;
        by = 20'sh0;
        bc = 20'sh0;
        lg = 5'h0;
        gmin = 4'h0;
        cur_luma = 5'h00;
        cur_gain = 4'h0;
        cur_stretch = 4'h0;
        cur_dark = 1'b0;
        st_d = st_q;

        // Register writes; page select answers on both pages
        if (reg_wr_en) begin
            if (reg_addr == `ACB_PAGE_OFS) begin
                st_d.page = reg_wdata;
            end else if (on_second(st_q.page) && reg_addr == `ACB_CTRL_OFS) begin
                st_d.en = reg_wdata[`ACB_EN_BIT]; // [R4]
            end else if (on_second(st_q.page) && reg_addr == `ACB_LUMA_OFS) begin
                st_d.luma_lvl = reg_wdata[4:0]; // [R7]
            end else if (on_second(st_q.page) && reg_addr == `ACB_CHROMA_OFS) begin
                st_d.sat = reg_wdata[3:0]; // [R8]
                st_d.clip = reg_wdata[7:4]; // [R9]
            end else if (on_second(st_q.page) && reg_addr == `ACB_RESP_OFS) begin
                st_d.speed = reg_wdata[7:4]; // [R10]
                st_d.stretch = reg_wdata[3:0]; // [R12]
            end
        end

        // Register reads; unmapped offsets read zero
        if (reg_rd_en) begin
            if (reg_addr == `ACB_PAGE_OFS) begin
                st_d.rd_data = st_q.page;
            end else if (on_second(st_q.page) && reg_addr == `ACB_CTRL_OFS) begin
                st_d.rd_data = {st_q.en, 7'h00};
            end else if (on_second(st_q.page) && reg_addr == `ACB_LUMA_OFS) begin
                st_d.rd_data = {3'h0, st_q.luma_lvl};
            end else if (on_second(st_q.page) && reg_addr == `ACB_CHROMA_OFS) begin
                st_d.rd_data = {st_q.clip, st_q.sat};
            end else if (on_second(st_q.page) && reg_addr == `ACB_RESP_OFS) begin
                st_d.rd_data = {st_q.speed, st_q.stretch};
            end else begin
                st_d.rd_data = 8'h00;
            end
        end

        // Histogram bins, saturating so a huge frame cannot wrap
        if (pix_valid) begin
            if (pix_y < `ACB_DARK_LIM && st_q.dark_cnt != `ACB_CNT_MAX) begin
                st_d.dark_cnt = st_q.dark_cnt + 16'h0001; // [R2]
            end
            if (pix_y >= `ACB_BRIGHT_LIM && st_q.bright_cnt != `ACB_CNT_MAX) begin
                st_d.bright_cnt = st_q.bright_cnt + 16'h0001; // [R2]
            end
        end

        // Frame boundary: settle the curve and step the blend
        if (frame_start) begin
            gmin = (st_q.sat < st_q.clip) ? st_q.sat : st_q.clip; // [R9]
            st_d.act_en = st_q.en; // [R15] [R3]
            st_d.act_luma = st_q.luma_lvl; // [R15]
            st_d.act_gain = gmin; // [R15]
            st_d.act_stretch = st_q.stretch; // [R15]
            st_d.dark_dom = st_q.dark_cnt > st_q.bright_cnt; // [R2]
            // The frame's first pixel opens the new histogram
            st_d.dark_cnt = (pix_valid && pix_y < `ACB_DARK_LIM) ? 16'h0001 : 16'h0000;
            st_d.bright_cnt = (pix_valid && pix_y >= `ACB_BRIGHT_LIM) ? 16'h0001 : 16'h0000;
            // Blend ramps up by speed+1 per frame; off drops straight to zero
            if (!st_q.en) begin
                st_d.alpha = 9'h000; // [R14]
            end else if (st_q.alpha > `ACB_ALPHA_FULL - {5'h00, st_q.speed} - 9'h001) begin
                st_d.alpha = `ACB_ALPHA_FULL; // [R11]
            end else begin
                st_d.alpha = st_q.alpha + {5'h00, st_q.speed} + 9'h001; // [R11]
            end
        end

        // Stage 1: correction curve, strength follows the histogram
        // The frame's first pixel already sees the new settings, so no frame mixes two curves
        cur_luma = frame_start ? st_q.luma_lvl : st_q.act_luma; // [R15]
        cur_gain = frame_start ? gmin : st_q.act_gain; // [R15] [R9]
        cur_stretch = frame_start ? st_q.stretch : st_q.act_stretch; // [R15]
        cur_dark = frame_start ? (st_q.dark_cnt > st_q.bright_cnt) : st_q.dark_dom; // [R2]
        lg = cur_dark ? cur_luma : {1'b0, cur_luma[4:1]}; // [R2]
        dev = $signed({12'h000, pix_y}) - `ACB_MID;
        yc = $signed({12'h000, pix_y}) + ((dev * $signed({15'h0000, lg})) >>> 4); // [R1]
        if (pix_y < `ACB_DARK_LIM) begin
            // Dark pixels are pushed further down to open up shadows
            yc = yc - (($signed({12'h000, `ACB_DARK_LIM - pix_y})
                      * $signed({16'h0000, cur_stretch})) >>> 3); // [R12]
        end
        dev = $signed({12'h000, pix_c}) - `ACB_MID;
        cc = `ACB_MID + ((dev * $signed({15'h0000, `ACB_UNITY_GAIN + {1'b0, cur_gain}}))
             >>> 4); // [R8] [R9]
        st_d.s1_valid = pix_valid;
        st_d.s1_orig_y = pix_y;
        st_d.s1_orig_c = pix_c;
        st_d.s1_corr_y = clamp8(yc);
        st_d.s1_corr_c = clamp8(cc);

        // Stage 2: fade corrected over original; alpha 0 is exact bypass
        by = $signed({12'h000, st_q.s1_orig_y})
             + ((($signed({12'h000, st_q.s1_corr_y}) - $signed({12'h000, st_q.s1_orig_y}))
             * $signed({11'h000, st_q.alpha})) >>> 8); // [R11] [R14]
        bc = $signed({12'h000, st_q.s1_orig_c})
             + ((($signed({12'h000, st_q.s1_corr_c}) - $signed({12'h000, st_q.s1_orig_c}))
             * $signed({11'h000, st_q.alpha})) >>> 8); // [R11] [R14]
        st_d.out_valid = st_q.s1_valid; // [R14]
        st_d.out_y = clamp8(by);
        st_d.out_c = clamp8(bc);
    end

    // ==========================================================
    // State register
    // ==========================================================
    // Synchronous reset to a disabled block with documented defaults
    always_ff @(posedge clock) begin
        if (srst) begin
            st_q <= '0;
            st_q.page <= `ACB_PAGE_USER;
            st_q.en <= 1'b0; // [R3]
            st_q.luma_lvl <= `ACB_LUMA_RST; // [R7]
            st_q.sat <= `ACB_SAT_RST; // [R8]
            st_q.clip <= `ACB_CLIP_RST; // [R9]
            st_q.speed <= `ACB_SPEED_RST; // [R10]
            st_q.stretch <= `ACB_STRETCH_RST; // [R12]
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs straight from flops
    assign reg_rdata = st_q.rd_data;
    assign out_valid = st_q.out_valid;
    assign out_y = st_q.out_y;
    assign out_c = st_q.out_c;

    // ==========================================================
    // Checks
    // ==========================================================
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    reset_defaults_a: assert property (disable iff (1'b0) srst |=> // [R3]
        (!st_q.en && !st_q.act_en && st_q.luma_lvl == `ACB_LUMA_RST
         && st_q.speed == `ACB_SPEED_RST && st_q.alpha == 9'h000))
        else $error("Reset left enhancement or defaults wrong");

    en_write_a: assert property ((reg_wr_en && reg_addr == `ACB_CTRL_OFS // [R4]
        && st_q.page == `ACB_PAGE_SECOND) |=> st_q.en == $past(reg_wdata[`ACB_EN_BIT]))
        else $error("Enable bit not taken from secondary page write");

    page_gate_a: assert property ((reg_wr_en && reg_addr == `ACB_CTRL_OFS // [R4]
        && st_q.page != `ACB_PAGE_SECOND) |=> $stable(st_q.en))
        else $error("Enable changed by user page write");

    luma_read_a: assert property ((reg_rd_en && reg_addr == `ACB_LUMA_OFS // [R7]
        && st_q.page == `ACB_PAGE_SECOND) |=> reg_rdata == {3'h0, $past(st_q.luma_lvl)})
        else $error("Luma level readback wrong");

    clip_gain_a: assert property (frame_start |=> // [R9]
        (st_q.act_gain <= $past(st_q.clip) && st_q.act_gain <= $past(st_q.sat)))
        else $error("Chroma gain above clip threshold");

    frame_apply_a: assert property ($changed(st_q.act_en) || $changed(st_q.act_luma) // [R15]
        |-> $past(frame_start))
        else $error("Parameters applied away from frame boundary");

    alpha_step_a: assert property ((frame_start && st_q.en // [R11]
        && st_q.alpha < 9'h0f0) |=> st_q.alpha == $past(st_q.alpha) + $past(st_q.speed) + 9'h001)
        else $error("Blend step does not follow response speed");

    alpha_off_a: assert property ((frame_start && !st_q.en) |=> // [R14]
        (st_q.alpha == 9'h000 && !st_q.act_en))
        else $error("Disable did not drop blend to zero");

    latency_fix_a: assert property (pix_valid |-> ##2 out_valid) // [R14]
        else $error("Pixel latency not two cycles");

    bypass_exact_a: assert property ((st_q.s1_valid && st_q.alpha == 9'h000) |=> // [R14]
        (out_y == $past(st_q.s1_orig_y) && out_c == $past(st_q.s1_orig_c)))
        else $error("Bypass altered samples");

    hist_count_a: assert property ((pix_valid && !frame_start && pix_y < `ACB_DARK_LIM // [R2]
        && st_q.dark_cnt != `ACB_CNT_MAX) |=> st_q.dark_cnt == $past(st_q.dark_cnt) + 16'h0001)
        else $error("Dark bin did not count");

    luma_write_a: assert property ((reg_wr_en && reg_addr == `ACB_LUMA_OFS // [R7]
        && st_q.page == `ACB_PAGE_SECOND) |=> st_q.luma_lvl == $past(reg_wdata[4:0]))
        else $error("Luma level not taken from secondary page write");

    chroma_write_a: assert property ((reg_wr_en && reg_addr == `ACB_CHROMA_OFS // [R8]
        && st_q.page == `ACB_PAGE_SECOND) |=> (st_q.sat == $past(reg_wdata[3:0])
        && st_q.clip == $past(reg_wdata[7:4])))
        else $error("Saturation or clip field not written");

    resp_write_a: assert property ((reg_wr_en && reg_addr == `ACB_RESP_OFS // [R10]
        && st_q.page == `ACB_PAGE_SECOND) |=> (st_q.speed == $past(reg_wdata[7:4])
        && st_q.stretch == $past(reg_wdata[3:0])))
        else $error("Speed or stretch field not written");

    ctrl_read_a: assert property ((reg_rd_en && reg_addr == `ACB_CTRL_OFS // [R4]
        && st_q.page == `ACB_PAGE_SECOND) |=> reg_rdata == {$past(st_q.en), 7'h00})
        else $error("Enable readback wrong");

    user_read_a: assert property ((reg_rd_en && reg_addr == `ACB_LUMA_OFS // [R7]
        && st_q.page != `ACB_PAGE_SECOND) |=> reg_rdata == 8'h00)
        else $error("Secondary register visible on user page");

    stretch_latch_a: assert property (frame_start |=> // [R12]
        st_q.act_stretch == $past(st_q.stretch))
        else $error("Stretch not taken at frame boundary");

    curve_hold_a: assert property ($changed(st_q.act_gain) || $changed(st_q.act_stretch) // [R15]
        |-> $past(frame_start))
        else $error("Curve settings changed inside a frame");

    // The blend weight only steps at frame starts, so a frame fades evenly
    alpha_hold_a: assert property (!frame_start |=> $stable(st_q.alpha)) // [R11]
        else $error("Blend weight moved inside a frame");

    dark_pull_a: assert property ((st_q.s1_valid && st_q.s1_orig_y < `ACB_MID_Y) |-> // [R1]
        st_q.s1_corr_y <= st_q.s1_orig_y)
        else $error("Dark pixel was brightened");

    bright_lift_a: assert property ((st_q.s1_valid && st_q.s1_orig_y >= `ACB_MID_Y) |-> // [R1]
        st_q.s1_corr_y >= st_q.s1_orig_y)
        else $error("Bright pixel was darkened");

    enable_seen_c: cover property (frame_start && st_q.en ##1 st_q.act_en);
    alpha_full_c: cover property (st_q.alpha == `ACB_ALPHA_FULL);
    dark_scene_c: cover property (st_q.dark_dom && st_q.act_en && out_valid);
    clip_active_c: cover property (frame_start && st_q.clip < st_q.sat);
    dark_stretch_c: cover property (st_q.s1_valid && st_q.act_stretch != 4'h0
        && st_q.s1_orig_y < `ACB_DARK_LIM);

endmodule

/* verilog/acb_defs.svh */
// Register offsets, field positions, reset values and limits of the contrast booster
`ifndef ACB_DEFS_SVH
`define ACB_DEFS_SVH
`define ACB_PAGE_OFS 8'h0e
`define ACB_PAGE_SECOND 8'h40
`define ACB_PAGE_USER 8'h00
`define ACB_CTRL_OFS 8'h80
`define ACB_LUMA_OFS 8'h83
`define ACB_CHROMA_OFS 8'h84
`define ACB_RESP_OFS 8'h85
`define ACB_EN_BIT 7
`define ACB_LUMA_RST 5'h0d
`define ACB_SAT_RST 4'h8
`define ACB_CLIP_RST 4'h8
`define ACB_SPEED_RST 4'hf
`define ACB_STRETCH_RST 4'h8
`define ACB_DARK_LIM 8'h40
`define ACB_BRIGHT_LIM 8'hc0
`define ACB_MID 16'sh0080
`define ACB_MID_Y 8'h80
`define ACB_ALPHA_FULL 9'h100
`define ACB_CNT_MAX 16'hffff
`define ACB_UNITY_GAIN 5'h10
`endif

/* verilog/acb_pkg.sv */
// Types shared by the contrast booster design
package acb_pkg;
    // All state of the block, registered as one word
    typedef struct packed {
        logic [7:0] page;       // Page select, 0x40 opens the secondary page
        logic en;               // Host enable (shadow)
        logic [4:0] luma_lvl;   // Host luma contrast level
        logic [3:0] sat;        // Host saturation level
        logic [3:0] clip;       // Host saturation clip threshold
        logic [3:0] speed;      // Host blend response speed
        logic [3:0] stretch;    // Host dark region stretch
        logic act_en;           // Frame-aligned copies below
        logic [4:0] act_luma;
        logic [3:0] act_gain;
        logic [3:0] act_stretch;
        logic dark_dom;         // Last frame had more dark than bright pixels
        logic [15:0] dark_cnt;  // Histogram bins of the running frame
        logic [15:0] bright_cnt;
        logic [8:0] alpha;      // Blend weight of the corrected image
        logic s1_valid;
        logic [7:0] s1_orig_y;
        logic [7:0] s1_orig_c;
        logic [7:0] s1_corr_y;
        logic [7:0] s1_corr_c;
        logic out_valid;
        logic [7:0] out_y;
        logic [7:0] out_c;
        logic [7:0] rd_data;
    } acb_state_t;
endpackage

/* test/acb_host_model.sv */
// Host side model that programs the booster over its register strobes
`timescale 1ns/10ps
`include "acb_defs.svh"
module acb_host_model (
    input wire logic clock,
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    // ==========================================
    // Strobe tasks
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = 8'h55;
        reg_wdata = 8'haa;
    end
    // Idle bus shows inverted values so a stale address never looks valid
    task automatic idle();
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
    // One write, strobe held over exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clock);
        idle();
    endtask
    // One read, data registered one edge later and held
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge clock);
        idle();
        d = reg_rdata;
    endtask
    // Enter the secondary page before any enhancement access
    task automatic open_page();
        wr(`ACB_PAGE_OFS, `ACB_PAGE_SECOND);
    endtask
    // Always return to the user page afterwards
    task automatic close_page();
        wr(`ACB_PAGE_OFS, `ACB_PAGE_USER);
    endtask
    // Full paged write; enable uses the same path as any level field
    task automatic put2(input logic [7:0] a, input logic [7:0] d);
        open_page();
        wr(a, d);
        close_page();
    endtask
endmodule

/* test/tb_top.sv */
// Self-checking bench for the contrast booster: registers, passthrough, blend
`timescale 1ns/10ps
`include "acb_defs.svh"
module tb_top;
    // ==========================================
    // Signals
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic frame_start = 1'b0;
    logic pix_valid = 1'b0;
    logic [7:0] pix_y = 8'h00;
    logic [7:0] pix_c = 8'h00;
    logic reg_wr_en, reg_rd_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, out_y, out_c, rv;
    logic out_valid;
    int errors = 0;
    int total_checks = 0;
    int cyc = 0;
    // ==========================================
    // Instances
    acb_contrast_boost i_acb_contrast_boost (.clock(clock), .srst(srst),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .frame_start(frame_start),
        .pix_valid(pix_valid), .pix_y(pix_y), .pix_c(pix_c), .out_valid(out_valid),
        .out_y(out_y), .out_c(out_c));
    acb_host_model i_acb_host_model (.clock(clock), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata));
    // ==========================================
    // Clock and hang guard
    initial begin
        forever #20 clock = ~clock;
    end
    // Whole run needs well under this many cycles
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            errors = errors + 1;
            stop_test();
        end
    end
    // ==========================================
    // Helpers
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    // Paged read with comparison
    task automatic get2(input logic [7:0] a, input logic [7:0] exp);
        i_acb_host_model.open_page();
        i_acb_host_model.rd(a, rv);
        i_acb_host_model.close_page();
        chk("paged register", rv, exp);
    endtask
    // One sample in, checked while its result stands after the second edge
    task automatic px(input logic [7:0] y, input logic [7:0] c, input logic fs,
                      input logic [7:0] ey, input logic [7:0] ec, input bit do_chk);
        @(negedge clock);
        pix_valid = 1'b1;
        frame_start = fs;
        pix_y = y;
        pix_c = c;
        @(negedge clock);
        pix_valid = 1'b0;
        frame_start = 1'b0;
        pix_y = ~y;
        pix_c = ~c;
        @(negedge clock);
        if (do_chk) begin
            chk("out_valid", {7'h00, out_valid}, 8'h01);
            chk("out_y", out_y, ey);
            chk("out_c", out_c, ec);
        end
    endtask
    // Frames of one bright sample each keep the histogram on the bright side
    task automatic frames(input int n);
        repeat (n) px(8'hc0, 8'h90, 1'b1, 8'h00, 8'h00, 1'b0);
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(negedge clock);
        srst = 1'b0;
        // Defaults after reset
        get2(`ACB_CTRL_OFS, 8'h00);
        get2(`ACB_LUMA_OFS, 8'h0d);
        get2(`ACB_CHROMA_OFS, 8'h88);
        get2(`ACB_RESP_OFS, 8'hf8);
        get2(8'h81, 8'h00);
        i_acb_host_model.rd(`ACB_LUMA_OFS, rv);
        chk("user page read", rv, 8'h00);
        // Disabled: exact passthrough at fixed latency, extremes too
        frames(2);
        px(8'h00, 8'hff, 1'b0, 8'h00, 8'hff, 1'b1);
        px(8'hff, 8'h00, 1'b0, 8'hff, 8'h00, 1'b1);
        // Level field width and readback
        i_acb_host_model.put2(`ACB_LUMA_OFS, 8'hff);
        get2(`ACB_LUMA_OFS, 8'h1f);
        i_acb_host_model.put2(`ACB_LUMA_OFS, 8'h0d);
        // Slowest speed: alpha 17 after 17 frames, luma moves one step, chroma not yet
        i_acb_host_model.put2(`ACB_RESP_OFS, 8'h08);
        i_acb_host_model.put2(`ACB_CTRL_OFS, 8'hff);
        get2(`ACB_CTRL_OFS, 8'h80);
        frames(17);
        px(8'hc0, 8'h90, 1'b0, 8'hc1, 8'h90, 1'b1);
        // Fastest speed: full blend, luma 0xc0 plus 24, chroma 0x90 plus 8
        i_acb_host_model.put2(`ACB_RESP_OFS, 8'hf8);
        frames(17);
        px(8'hc0, 8'h90, 1'b0, 8'hd8, 8'h98, 1'b1);
        // Clip below saturation level caps chroma gain at 2
        i_acb_host_model.put2(`ACB_CHROMA_OFS, 8'h2f);
        get2(`ACB_CHROMA_OFS, 8'h2f);
        px(8'hc0, 8'h90, 1'b0, 8'hd8, 8'h98, 1'b1);
        frames(1);
        px(8'hc0, 8'h90, 1'b0, 8'hd8, 8'h92, 1'b1);
        // Dark frame: full luma level plus shadow stretch, first pixel on the new curve
        px(8'h20, 8'h80, 1'b1, 8'h00, 8'h00, 1'b0);
        px(8'h3f, 8'h80, 1'b1, 8'h09, 8'h80, 1'b1);
        px(8'h60, 8'h80, 1'b0, 8'h46, 8'h80, 1'b1);
        // Disable returns to plain passthrough after the next frame
        i_acb_host_model.put2(`ACB_CTRL_OFS, 8'h00);
        frames(1);
        px(8'hc0, 8'h90, 1'b0, 8'hc0, 8'h90, 1'b1);
        stop_test();
    end
endmodule
